// *** common/rsse_regs.svh ***
`ifndef RSSE_REGS_SVH
`define RSSE_REGS_SVH

`define RSSE_DATA_W        8
`define RSSE_ADDR_W        7
`define RSSE_PC_W          15
`define RSSE_FILE_MAX      7'h7F
`define RSSE_WDT_CLEAR     8'h00
`define RSSE_ACC_RST       8'h00
`define RSSE_PC_RST        15'h0000
`define RSSE_RETURN_CYCLES 2
`define RSSE_DEST_ACC      1'b0
`define RSSE_DEST_FILE     1'b1

`endif

// *** common/rsse_pkg.sv ***
`include "rsse_regs.svh"

package rsse_pkg;

  typedef enum logic [2:0] {
    RSSE_OP_NONE,
    RSSE_OP_ROTL,
    RSSE_OP_ROTR,
    RSSE_OP_SUBL,
    RSSE_OP_SLEEP,
    RSSE_OP_RETURN
  } rsse_op_type;

  typedef struct packed {
    rsse_op_type                 op;
    logic                        destFile;
    logic [`RSSE_ADDR_W-1:0]     fileAddr;
    logic [`RSSE_DATA_W-1:0]     operand;
  } rsse_instr_type;

  typedef struct packed {
    logic carry;
    logic nibbleCarry;
    logic zero;
  } rsse_flags_type;

  typedef struct packed {
    logic                        write;
    logic [`RSSE_ADDR_W-1:0]     addr;
    logic [`RSSE_DATA_W-1:0]     data;
  } rsse_file_wr_type;

endpackage

// *** src/rsse_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rsse_regs.svh"

module rsse_alu
  import rsse_pkg::*;
(
  input  wire rsse_op_type              op,
  input  wire logic [`RSSE_DATA_W-1:0]  operand,
  input  wire logic [`RSSE_DATA_W-1:0]  acc,
  input  wire logic                     carryIn,
  output logic      [`RSSE_DATA_W-1:0]  result,
  output rsse_flags_type                flags
);

  logic [`RSSE_DATA_W:0] diff;
  logic [4:0]            lowDiff;

  always_comb begin
    diff    = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
    lowDiff = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    result  = operand;
    flags   = '{carry: carryIn, nibbleCarry: 1'b0, zero: 1'b0};
    unique case (op)
      RSSE_OP_ROTL: begin
        result      = {operand[6:0], carryIn};
        flags.carry = operand[7];
      end
      RSSE_OP_ROTR: begin
        result      = {carryIn, operand[7:1]};
        flags.carry = operand[0];
      end
      RSSE_OP_SUBL: begin
        result            = diff[7:0];
        flags.carry       = diff[8];
        flags.nibbleCarry = lowDiff[4];
        flags.zero        = (diff[7:0] == 8'h00);
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule // rsse_alu

`default_nettype wire

// *** src/rsse_exec.sv ***
// Functional notes
// - rotate left: old carry in, bit7 out
// - rotate right: old carry in, bit0 out
// - destination bit picks accumulator or file; carry only
// - sleep clears watchdog, prescaler; sets timeout, clears powerdown
// - literal minus accumulator into accumulator
// - return pops stack into PC, two cycles
`timescale 1ns/1ns
`default_nettype none
`include "rsse_regs.svh"

module rsse_exec
  import rsse_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     instrValid,
  input  wire rsse_instr_type           instr,
  input  wire logic [`RSSE_PC_W-1:0]    stackTop,
  output logic                          instrReady,
  output logic      [`RSSE_DATA_W-1:0]  accQ,
  output rsse_flags_type                flagsQ,
  output rsse_file_wr_type              fileWrQ,
  output logic      [`RSSE_PC_W-1:0]    pcQ,
  output logic                          pcLoadQ,
  output logic                          stackPopQ,
  output logic                          watchdogClearQ,
  output logic                          prescalerClearQ,
  output logic      [`RSSE_DATA_W-1:0]  watchdogValueQ,
  output logic                          timeoutFlagQ,
  output logic                          powerdownFlagQ,
  output logic                          sleepQ
);

  // ----------------------------------------
  // decode and datapath
  // ----------------------------------------
  typedef enum logic {RSSE_ST_IDLE, RSSE_ST_RET2} rsse_state_type;

  rsse_state_type                  stateQ;
  logic [`RSSE_DATA_W-1:0]         aluResult;
  rsse_flags_type                  aluFlags;
  logic                            take;

  function automatic logic isOp(input rsse_instr_type i, input rsse_op_type o);
    return i.op == o;
  endfunction

  // a return blocks a second instruction for its second cycle
  assign instrReady = (stateQ == RSSE_ST_IDLE);
  assign take       = instrValid && instrReady;

  rsse_alu u_alu (
    .op      (instr.op),
    .operand (instr.operand),
    .acc     (accQ),
    .carryIn (flagsQ.carry),
    .result  (aluResult),
    .flags   (aluFlags)
  );

  // ----------------------------------------
  // accumulator and flags
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      accQ   <= `RSSE_ACC_RST;
      flagsQ <= '0;
    end else if (take) begin
      if (isOp(instr, RSSE_OP_ROTL) || isOp(instr, RSSE_OP_ROTR)) begin
        flagsQ.carry <= aluFlags.carry;
        if (instr.destFile == `RSSE_DEST_ACC) begin
          accQ <= aluResult;
        end
      end else if (isOp(instr, RSSE_OP_SUBL)) begin
        accQ   <= aluResult;
        flagsQ <= aluFlags;
      end
    end
  end

  // ----------------------------------------
  // file register write-back
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fileWrQ <= '0;
    end else begin
      fileWrQ.write <= take && (isOp(instr, RSSE_OP_ROTL) || isOp(instr, RSSE_OP_ROTR))
                       && instr.destFile == `RSSE_DEST_FILE;
      fileWrQ.addr  <= instr.fileAddr;
      fileWrQ.data  <= aluResult;
    end
  end

  // ----------------------------------------
  // sleep entry
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdogClearQ  <= 1'b0;
      prescalerClearQ <= 1'b0;
      watchdogValueQ  <= `RSSE_WDT_CLEAR;
      timeoutFlagQ    <= 1'b1;
      powerdownFlagQ  <= 1'b1;
      sleepQ          <= 1'b0;
    end else begin
      watchdogClearQ  <= take && isOp(instr, RSSE_OP_SLEEP);
      prescalerClearQ <= take && isOp(instr, RSSE_OP_SLEEP);
      if (take && isOp(instr, RSSE_OP_SLEEP)) begin
        watchdogValueQ <= `RSSE_WDT_CLEAR;
        timeoutFlagQ   <= 1'b1;
        powerdownFlagQ <= 1'b0;
        sleepQ         <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // subroutine return
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stateQ    <= RSSE_ST_IDLE;
      pcQ       <= `RSSE_PC_RST;
      pcLoadQ   <= 1'b0;
      stackPopQ <= 1'b0;
    end else begin
      pcLoadQ   <= 1'b0;
      stackPopQ <= 1'b0;
      unique case (stateQ)
        RSSE_ST_IDLE: begin
          if (take && isOp(instr, RSSE_OP_RETURN)) begin
            pcQ       <= stackTop;
            pcLoadQ   <= 1'b1;
            stackPopQ <= 1'b1;
            stateQ    <= RSSE_ST_RET2;
          end
        end
        RSSE_ST_RET2: begin
          stateQ <= RSSE_ST_IDLE;
        end
      endcase
    end
  end

endmodule // rsse_exec

`default_nettype wire

// *** tb/rsse_exec_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsse_exec_sva
  import rsse_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             instrValid,
  input wire rsse_instr_type   instr,
  input wire logic [14:0]      stackTop,
  input wire logic             instrReady,
  input wire logic [7:0]       accQ,
  input wire rsse_flags_type   flagsQ,
  input wire rsse_file_wr_type fileWrQ,
  input wire logic [14:0]      pcQ,
  input wire logic             pcLoadQ,
  input wire logic             stackPopQ,
  input wire logic             watchdogClearQ,
  input wire logic             prescalerClearQ,
  input wire logic [7:0]       watchdogValueQ,
  input wire logic             timeoutFlagQ,
  input wire logic             powerdownFlagQ,
  input wire logic             sleepQ
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic       destQ;
  logic [7:0] res;
  logic [8:0] dif;
  always_ff @(posedge sys_clk) destQ <= instr.destFile;
  assign res = destQ ? fileWrQ.data : accQ;
  // borrow shows in bit 8
  assign dif = {1'b0, instr.operand} - {1'b0, accQ};
  sequence s_take(rsse_op_type o);
    instrValid && instrReady && instr.op == o;
  endsequence
  sequence s_ret;
    pcLoadQ && stackPopQ && !instrReady && pcQ == $past(stackTop) ##1 instrReady;
  endsequence
  property p_rotl;
    s_take(RSSE_OP_ROTL) |=> res == $past({instr.operand[6:0], flagsQ.carry})
      && flagsQ.carry == $past(instr.operand[7]);
  endproperty
  property p_rotr;
    s_take(RSSE_OP_ROTR) |=> res == $past({flagsQ.carry, instr.operand[7:1]})
      && flagsQ.carry == $past(instr.operand[0]);
  endproperty
  property p_dest;
    instrValid && instrReady && instr.op inside {RSSE_OP_ROTL, RSSE_OP_ROTR}
      |=> fileWrQ.write == $past(instr.destFile) && $stable({flagsQ.nibbleCarry, flagsQ.zero});
  endproperty
  property p_sleep;
    s_take(RSSE_OP_SLEEP) |=> watchdogClearQ && prescalerClearQ && watchdogValueQ == 8'h00
      && timeoutFlagQ && !powerdownFlagQ && sleepQ;
  endproperty
  property p_sub;
    s_take(RSSE_OP_SUBL) |=> accQ == $past(dif[7:0]);
  endproperty
  property p_subflag;
    s_take(RSSE_OP_SUBL) |=> flagsQ == {$past(!dif[8]),
      $past(instr.operand[3:0] >= accQ[3:0]), $past(dif[7:0] == 8'h00)};
  endproperty
  property p_ret;
    s_take(RSSE_OP_RETURN) |=> s_ret;
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left wrong");
  a_rotr: assert property (p_rotr) else $error("rotate right wrong");
  a_dest: assert property (p_dest) else $error("rotate target wrong");
  a_sleep: assert property (p_sleep) else $error("sleep wrong");
  a_sub: assert property (p_sub) else $error("subtract wrong");
  a_subflag: assert property (p_subflag) else $error("subtract flags wrong");
  a_ret: assert property (p_ret) else $error("return wrong");
endmodule // rsse_exec_sva
bind rsse_exec rsse_exec_sva chk_u (.*);
`default_nettype wire

// *** tb/rsse_exec_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsse_exec_tb
  import rsse_pkg::*;
;
  logic             sys_clk = 1'b0, rst_n = 1'b0, instrValid = 1'b0;
  rsse_instr_type   instr = '0;
  logic [14:0]      stackTop = 15'h0000, pcQ;
  logic [7:0]       accQ, watchdogValueQ, accM = 8'h00;
  rsse_flags_type   flagsQ;
  rsse_file_wr_type fileWrQ;
  logic             instrReady, pcLoadQ, stackPopQ, watchdogClearQ, prescalerClearQ;
  logic             timeoutFlagQ, powerdownFlagQ, sleepQ, cM = 1'b0, nM = 1'b0, zM = 1'b0;
  logic [31:0]      seed = 32'hE6D6;
  int               errTotal = 0, numChecks = 0;
  rsse_exec dut_u (.*);
  always #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic doOp(input rsse_op_type o, input logic d, input logic [7:0] v);
    logic [7:0] r;
    instr = '{o, d, v[6:0], v};
    instrValid = 1'b1;
    stackTop = {v[6:0], v};
    r = (o == RSSE_OP_ROTL) ? {v[6:0], cM} : (o == RSSE_OP_ROTR) ? {cM, v[7:1]} : v - accM;
    @(negedge sys_clk);
    if (o == RSSE_OP_RETURN) begin
      chk({pcQ, pcLoadQ, stackPopQ, instrReady}, {stackTop, 3'h6});
      instrValid = 1'b0;
      @(negedge sys_clk);
      chk(instrReady, 1'h1);
    end else if (o == RSSE_OP_SLEEP) begin
      chk({watchdogClearQ, prescalerClearQ, watchdogValueQ, timeoutFlagQ, powerdownFlagQ,
        sleepQ}, {2'h3, 8'h00, 3'h5});
    end else begin
      if (o == RSSE_OP_SUBL) begin
        {cM, nM, zM} = {v >= accM, v[3:0] >= accM[3:0], r == 8'h00};
        accM = r;
      end else begin
        cM = (o == RSSE_OP_ROTL) ? v[7] : v[0];
        if (!d) accM = r;
        chk({fileWrQ.write, fileWrQ.addr, d ? fileWrQ.data : r}, {d, v[6:0], r});
      end
      chk({accQ, flagsQ}, {accM, cM, nM, zM});
    end
  endtask
  task automatic testDone();
    if (errTotal == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    chk({timeoutFlagQ, powerdownFlagQ, sleepQ, instrReady, accQ}, {4'hD, 8'h00});
    doOp(RSSE_OP_ROTL, 1'b0, 8'hE6);
    doOp(RSSE_OP_ROTR, 1'b1, 8'h01);
    doOp(RSSE_OP_SUBL, 1'b0, 8'h00);
    doOp(RSSE_OP_SUBL, 1'b0, accM);
    // sleep left to the end: nothing wakes the core here
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      doOp(seed[9:8] == 2'h3 ? RSSE_OP_RETURN : rsse_op_type'(3'(seed[9:8] + 2'h1)),
        seed[10], seed[7:0]);
    end
    doOp(RSSE_OP_SLEEP, 1'b0, 8'h00);
    testDone();
  end
endmodule // rsse_exec_tb
`default_nettype wire
